// file: design/tsohu_top.sv
// Decided for this implementation: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ns
module tsohu_top (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] pl_data,
	input wire logic [3:0] pl_keep,
	input wire logic pl_valid,
	output logic pl_ready,
	output logic seg_valid,
	input wire logic seg_ready,
	output logic seg_last,
	output logic [15:0] seg_payload_len,
	output logic [15:0] seg_l4_len,
	output logic [15:0] seg_ip_len,
	output logic [15:0] seg_ip_id,
	output logic [15:0] seg_ip_csum,
	output logic seg_ip_csum_en,
	output logic [7:0] seg_tcp_flags,
	output logic [15:0] seg_l4_csum,
	output logic seg_l4_csum_en
);
	// End-around-carry 16-bit one's complement add
	function automatic logic [15:0] csum_add(input logic [15:0] a, input logic [15:0] b);
		logic [16:0] s;
		s = {1'b0, a} + {1'b0, b};
		return s[15:0] + {15'h0000, s[16]};
	endfunction : csum_add

	// Byte-enable merge for register writes
	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
		input logic [3:0] st);
		logic [31:0] r;
		r = o;
		for (int i = 0; i < 4; i++) begin
			if (st[i]) begin
				r[i*8 +: 8] = n[i*8 +: 8];
			end
		end
		return r;
	endfunction : merge

	tsohu_pkg::tsohu_state_t state_ff, nxt_state;
	logic [31:0] ctrl_ff, mss_ff, paylen_ff, hdrlen_ff, ipid_ff, pseudo_ff;
	logic [31:0] l4sum_ff, ipsum_ff, flags_ff;
	logic [7:0] awaddr_ff;
	logic aw_full_ff, w_full_ff;
	logic [31:0] wdata_ff;
	logic [3:0] wstrb_ff;
	logic [19:0] remain_ff;
	logic [15:0] id_ff, bytes_ff, sum_ff;

	// Write channel: address and data latched in either order
	wire aw_hs = s_axi_awvalid && s_axi_awready;
	wire w_hs = s_axi_wvalid && s_axi_wready;
	wire do_wr = aw_full_ff && w_full_ff && !s_axi_bvalid;
	wire wr_hit = (awaddr_ff <= tsohu_pkg::ADDR_FLAGS) && (awaddr_ff[1:0] == 2'b00);
	assign s_axi_awready = !aw_full_ff;
	assign s_axi_wready = !w_full_ff;
	assign s_axi_arready = !s_axi_rvalid;
	wire wr_ctrl = do_wr && awaddr_ff == tsohu_pkg::ADDR_CTRL;
	wire [31:0] ctrl_wr = merge(ctrl_ff, wdata_ff, wstrb_ff);
	wire start = wr_ctrl && ctrl_wr[tsohu_pkg::CTRL_START] && state_ff == tsohu_pkg::ST_IDLE
		&& paylen_ff[19:0] != 20'h00000 && mss_ff[15:0] != 16'h0000;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_ff <= 1'b0;
			w_full_ff <= 1'b0;
			awaddr_ff <= 8'h00;
			wdata_ff <= tsohu_pkg::RST_ZERO;
			wstrb_ff <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= tsohu_pkg::RESP_OKAY;
		end else begin
			if (aw_hs) begin
				aw_full_ff <= 1'b1;
				awaddr_ff <= s_axi_awaddr;
			end else if (do_wr) begin
				aw_full_ff <= 1'b0;
			end
			if (w_hs) begin
				w_full_ff <= 1'b1;
				wdata_ff <= s_axi_wdata;
				wstrb_ff <= s_axi_wstrb;
			end else if (do_wr) begin
				w_full_ff <= 1'b0;
			end
			if (do_wr) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_hit ? tsohu_pkg::RESP_OKAY : tsohu_pkg::RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Register file; start bit never stored
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_ff <= tsohu_pkg::RST_ZERO;
			mss_ff <= tsohu_pkg::RST_ZERO;
			paylen_ff <= tsohu_pkg::RST_ZERO;
			hdrlen_ff <= tsohu_pkg::RST_ZERO;
			ipid_ff <= tsohu_pkg::RST_ZERO;
			pseudo_ff <= tsohu_pkg::RST_ZERO;
			l4sum_ff <= tsohu_pkg::RST_ZERO;
			ipsum_ff <= tsohu_pkg::RST_ZERO;
			flags_ff <= tsohu_pkg::RST_ZERO;
		end else if (do_wr) begin
			case (awaddr_ff)
				tsohu_pkg::ADDR_CTRL: ctrl_ff <= {ctrl_wr[31:1], 1'b0};
				tsohu_pkg::ADDR_MSS: mss_ff <= merge(mss_ff, wdata_ff, wstrb_ff);
				tsohu_pkg::ADDR_PAYLEN: paylen_ff <= merge(paylen_ff, wdata_ff, wstrb_ff);
				tsohu_pkg::ADDR_HDRLEN: hdrlen_ff <= merge(hdrlen_ff, wdata_ff, wstrb_ff);
				tsohu_pkg::ADDR_IPID: ipid_ff <= merge(ipid_ff, wdata_ff, wstrb_ff);
				tsohu_pkg::ADDR_PSEUDO: pseudo_ff <= merge(pseudo_ff, wdata_ff, wstrb_ff);
				tsohu_pkg::ADDR_L4SUM: l4sum_ff <= merge(l4sum_ff, wdata_ff, wstrb_ff);
				tsohu_pkg::ADDR_IPSUM: ipsum_ff <= merge(ipsum_ff, wdata_ff, wstrb_ff);
				tsohu_pkg::ADDR_FLAGS: flags_ff <= merge(flags_ff, wdata_ff, wstrb_ff);
				default: ;
			endcase
		end
	end

	// Read mux; unmapped reads answer zero with an error
	wire busy = state_ff != tsohu_pkg::ST_IDLE;
	logic [31:0] rd_mux;
	logic rd_hit;
	always_comb begin
		rd_hit = 1'b1;
		case (s_axi_araddr)
			tsohu_pkg::ADDR_CTRL: rd_mux = ctrl_ff;
			tsohu_pkg::ADDR_MSS: rd_mux = mss_ff;
			tsohu_pkg::ADDR_PAYLEN: rd_mux = paylen_ff;
			tsohu_pkg::ADDR_HDRLEN: rd_mux = hdrlen_ff;
			tsohu_pkg::ADDR_IPID: rd_mux = ipid_ff;
			tsohu_pkg::ADDR_PSEUDO: rd_mux = pseudo_ff;
			tsohu_pkg::ADDR_L4SUM: rd_mux = l4sum_ff;
			tsohu_pkg::ADDR_IPSUM: rd_mux = ipsum_ff;
			tsohu_pkg::ADDR_FLAGS: rd_mux = flags_ff;
			tsohu_pkg::ADDR_STATUS: rd_mux = {remain_ff, 11'h000, busy};
			default: begin
				rd_mux = tsohu_pkg::RST_ZERO;
				rd_hit = 1'b0;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= tsohu_pkg::RST_ZERO;
			s_axi_rresp <= tsohu_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_mux;
			s_axi_rresp <= rd_hit ? tsohu_pkg::RESP_OKAY : tsohu_pkg::RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// Per-segment lengths from the live context
	wire is_v6 = ctrl_ff[tsohu_pkg::CTRL_IPV6];
	wire is_udp = ctrl_ff[tsohu_pkg::CTRL_UDP];
	wire [3:0] tcp_words = hdrlen_ff[tsohu_pkg::HDR_TCPW_LSB +: 4];
	wire [15:0] ip_hdr_bytes = {8'h00, hdrlen_ff[tsohu_pkg::HDR_IP_LSB +: 8]};
	wire [15:0] l4_hdr_bytes = is_udp ? tsohu_pkg::UDP_HDR_BYTES
		: {10'h000, tcp_words, 2'b00};
	wire last = remain_ff <= {4'h0, mss_ff[15:0]};
	wire [15:0] pay_len = last ? remain_ff[15:0] : mss_ff[15:0];
	wire [15:0] l4_len = 16'(pay_len + l4_hdr_bytes);
	wire [15:0] ip_len = 16'(l4_len + ip_hdr_bytes);

	// Flags: template kept, push and finish on last only
	wire [7:0] pf_mask = tsohu_pkg::TCP_PSH_MASK | tsohu_pkg::TCP_FIN_MASK;
	wire [7:0] pf_set = (ctrl_ff[tsohu_pkg::CTRL_PSH] ? tsohu_pkg::TCP_PSH_MASK : 8'h00)
		| (ctrl_ff[tsohu_pkg::CTRL_FIN] ? tsohu_pkg::TCP_FIN_MASK : 8'h00);
	wire [7:0] tcp_flags = (flags_ff[7:0] & ~pf_mask) | (last ? pf_set : 8'h00);
	wire [15:0] flag_word = is_udp ? 16'h0000 : {tcp_words, 4'h0, tcp_flags};

	// Payload beat: little-endian lanes, byte 0 is the high half of word 0
	wire pl_hs = pl_valid && pl_ready;
	wire [7:0] b0 = pl_keep[0] ? pl_data[7:0] : 8'h00;
	wire [7:0] b1 = pl_keep[1] ? pl_data[15:8] : 8'h00;
	wire [7:0] b2 = pl_keep[2] ? pl_data[23:16] : 8'h00;
	wire [7:0] b3 = pl_keep[3] ? pl_data[31:24] : 8'h00;
	wire [15:0] beat_sum = csum_add(csum_add(sum_ff, {b0, b1}), {b2, b3});
	wire [2:0] beat_bytes = 3'({2'b00, pl_keep[0]} + {2'b00, pl_keep[1]}
		+ {2'b00, pl_keep[2]} + {2'b00, pl_keep[3]});
	wire [15:0] bytes_nxt = 16'(bytes_ff + {13'h0000, beat_bytes});
	wire seg_done = pl_hs && bytes_nxt >= pay_len;
	assign pl_ready = state_ff == tsohu_pkg::ST_SUM;

	// Transport checksum: pseudo partial plus length plus header plus payload
	wire [15:0] ps_len = csum_add(pseudo_ff[15:0], l4_len);
	wire [15:0] hdr_part = csum_add(csum_add(l4sum_ff[15:0], flag_word),
		is_udp ? l4_len : 16'h0000);
	wire [15:0] l4_raw = ~csum_add(csum_add(ps_len, hdr_part), beat_sum);
	wire [15:0] l4_fix = (is_v6 && is_udp && l4_raw == 16'h0000)
		? tsohu_pkg::CSUM_ONES : l4_raw;
	// IPv4 header checksum redone with this segment's length and id
	wire [15:0] ip_raw = ~csum_add(csum_add(ipsum_ff[15:0], ip_len), id_ff);

	// Segment sequencer
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			tsohu_pkg::ST_IDLE: if (start) nxt_state = tsohu_pkg::ST_SUM;
			tsohu_pkg::ST_SUM: if (seg_done) nxt_state = tsohu_pkg::ST_OUT;
			tsohu_pkg::ST_OUT: if (seg_ready) nxt_state = last ? tsohu_pkg::ST_IDLE
				: tsohu_pkg::ST_SUM;
			default: nxt_state = tsohu_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_ff <= tsohu_pkg::ST_IDLE;
			remain_ff <= 20'h00000;
			id_ff <= 16'h0000;
			bytes_ff <= 16'h0000;
			sum_ff <= 16'h0000;
		end else begin
			state_ff <= nxt_state;
			if (start) begin
				remain_ff <= paylen_ff[19:0];
				id_ff <= ipid_ff[15:0];
			end else if (state_ff == tsohu_pkg::ST_OUT && seg_ready) begin
				remain_ff <= remain_ff - {4'h0, pay_len};
				id_ff <= 16'(id_ff + 16'h0001);
			end
			if (start || state_ff == tsohu_pkg::ST_OUT) begin
				bytes_ff <= 16'h0000;
				sum_ff <= 16'h0000;
			end else if (pl_hs) begin
				bytes_ff <= bytes_nxt;
				sum_ff <= beat_sum;
			end
		end
	end

	// Segment result registers; IP flags and offset never touched here
	assign seg_valid = state_ff == tsohu_pkg::ST_OUT;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			seg_last <= 1'b0;
			seg_payload_len <= 16'h0000;
			seg_l4_len <= 16'h0000;
			seg_ip_len <= 16'h0000;
			seg_ip_id <= 16'h0000;
			seg_ip_csum <= 16'h0000;
			seg_ip_csum_en <= 1'b0;
			seg_tcp_flags <= 8'h00;
			seg_l4_csum <= 16'h0000;
			seg_l4_csum_en <= 1'b0;
		end else if (state_ff == tsohu_pkg::ST_SUM && seg_done) begin
			seg_last <= last;
			seg_payload_len <= pay_len;
			seg_l4_len <= l4_len;
			seg_ip_len <= ip_len;
			seg_ip_id <= id_ff;
			seg_ip_csum <= ip_raw;
			seg_ip_csum_en <= !is_v6;
			seg_tcp_flags <= is_udp ? 8'h00 : tcp_flags;
			seg_l4_csum <= l4_fix;
			seg_l4_csum_en <= !is_udp || ctrl_ff[tsohu_pkg::CTRL_CSUM];
		end
	end

	// Checks
	sequence seg_take_s;
		seg_valid && seg_ready && !seg_last;
	endsequence
	sequence next_seg_s;
		!seg_valid && pl_ready;
	endsequence

	id_step_a: assert property (@(posedge aclk) disable iff (!aresetn)
		seg_take_s |=> id_ff == $past(seg_ip_id) + 16'h0001)
		else $error("identification did not step by one");
	v6_no_hcs_a: assert property (@(posedge aclk) disable iff (!aresetn)
		seg_valid && is_v6 |-> !seg_ip_csum_en)
		else $error("header checksum enabled on IPv6");
	ip_len_a: assert property (@(posedge aclk) disable iff (!aresetn)
		seg_valid |-> seg_ip_len == 16'(seg_l4_len + ip_hdr_bytes))
		else $error("IP length mismatch");
	l4_len_a: assert property (@(posedge aclk) disable iff (!aresetn)
		seg_valid |-> seg_l4_len == 16'(seg_payload_len + l4_hdr_bytes))
		else $error("transport length mismatch");
	seg_size_a: assert property (@(posedge aclk) disable iff (!aresetn)
		seg_valid && !seg_last |-> seg_payload_len == mss_ff[15:0])
		else $error("non-final segment not full size");
	flag_copy_a: assert property (@(posedge aclk) disable iff (!aresetn)
		seg_valid && !is_udp |-> (seg_tcp_flags & ~pf_mask) == (flags_ff[7:0] & ~pf_mask))
		else $error("TCP flags not copied");
	pf_early_a: assert property (@(posedge aclk) disable iff (!aresetn)
		seg_valid && !seg_last |-> (seg_tcp_flags & pf_mask) == 8'h00)
		else $error("push or finish on early segment");
	udp_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
		seg_valid && is_v6 && is_udp |-> seg_l4_csum != 16'h0000)
		else $error("zero UDP checksum on IPv6");
	udp_keep_a: assert property (@(posedge aclk) disable iff (!aresetn)
		seg_valid && is_udp && !ctrl_ff[tsohu_pkg::CTRL_CSUM] |-> !seg_l4_csum_en)
		else $error("UDP checksum written without insert bit");
	seg_order_a: assert property (@(posedge aclk) disable iff (!aresetn)
		seg_take_s |=> next_seg_s)
		else $error("next segment did not restart payload collection");
endmodule : tsohu_top

// file: design/tsohu_pkg.sv
package tsohu_pkg;
	// Register byte addresses
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_MSS = 8'h04;
	localparam logic [7:0] ADDR_PAYLEN = 8'h08;
	localparam logic [7:0] ADDR_HDRLEN = 8'h0C;
	localparam logic [7:0] ADDR_IPID = 8'h10;
	localparam logic [7:0] ADDR_PSEUDO = 8'h14;
	localparam logic [7:0] ADDR_L4SUM = 8'h18;
	localparam logic [7:0] ADDR_IPSUM = 8'h1C;
	localparam logic [7:0] ADDR_FLAGS = 8'h20;
	localparam logic [7:0] ADDR_STATUS = 8'h24;
	// Control register bits
	localparam int CTRL_START = 0;
	localparam int CTRL_IPV6 = 1;
	localparam int CTRL_UDP = 2;
	localparam int CTRL_CSUM = 3;
	localparam int CTRL_PSH = 4;
	localparam int CTRL_FIN = 5;
	// Header length register fields
	localparam int HDR_IP_LSB = 8;
	localparam int HDR_TCPW_LSB = 0;
	// TCP flag positions inside the flags byte
	localparam logic [7:0] TCP_PSH_MASK = 8'h08;
	localparam logic [7:0] TCP_FIN_MASK = 8'h01;
	localparam logic [15:0] UDP_HDR_BYTES = 16'h0008;
	localparam logic [15:0] CSUM_ONES = 16'hFFFF;
	// Reset values and response codes
	localparam logic [31:0] RST_ZERO = 32'h0000_0000;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_SUM = 2'b01,
		ST_OUT = 2'b10
	} tsohu_state_t;
endpackage : tsohu_pkg

// file: sim/tsohu_src.sv
`timescale 1ns/1ns
// Payload source standing in for the host memory fetch path
module tsohu_src #(
	parameter logic [31:0] WORD = 32'h4433_2211
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic stall,
	input wire logic pl_ready,
	output logic [31:0] pl_data,
	output logic [3:0] pl_keep,
	output logic pl_valid
);
	// Offer a word, hold it until taken; idle data shows the inverse
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pl_valid <= 1'h0;
			pl_data <= ~WORD;
		end else if (!pl_valid || pl_ready) begin
			pl_valid <= !stall;
			pl_data <= stall ? ~WORD : WORD;
		end
	end
	assign pl_keep = 4'hF; // Whole words only
endmodule : tsohu_src

// file: sim/tb_top.sv
`timescale 1ns/1ns
// Self-checking bench for the segment header updater
module tb_top;
	logic aclk = 1'h0;
	logic aresetn = 1'h0;
	logic [7:0] s_axi_awaddr = 8'h00;
	logic [7:0] s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'h0;
	logic s_axi_wvalid = 1'h0;
	logic s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0;
	logic s_axi_rready = 1'h0;
	logic seg_ready = 1'h0;
	logic src_stall = 1'h0;
	logic slow = 1'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata, pl_data;
	logic [3:0] pl_keep;
	logic pl_valid, pl_ready, seg_valid, seg_last, seg_ip_csum_en, seg_l4_csum_en;
	logic [15:0] seg_payload_len, seg_l4_len, seg_ip_len, seg_ip_id, seg_ip_csum, seg_l4_csum;
	logic [7:0] seg_tcp_flags;
	int failures = 0;
	int tests_run = 0;

	tsohu_top i_tsohu_top (
		.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pl_data, .pl_keep, .pl_valid,
		.pl_ready, .seg_valid, .seg_ready, .seg_last, .seg_payload_len, .seg_l4_len,
		.seg_ip_len, .seg_ip_id, .seg_ip_csum, .seg_ip_csum_en, .seg_tcp_flags,
		.seg_l4_csum, .seg_l4_csum_en
	);
	tsohu_src i_tsohu_src (.aclk, .aresetn, .stall(src_stall), .pl_ready, .pl_data,
		.pl_keep, .pl_valid);

	// Clock and the slow-source stall pattern
	always #5 aclk = ~aclk;
	always @(posedge aclk) src_stall <= slow && !src_stall;

	task automatic summarize();
		$display("failures=%0d tests_run=%0d", failures, tests_run);
		if (failures == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : summarize

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	// One's complement add with end-around carry
	function automatic logic [15:0] oc(input logic [15:0] a, input logic [15:0] b);
		logic [16:0] s;
		s = {1'h0, a} + {1'h0, b};
		return s[15:0] + {15'h0, s[16]};
	endfunction : oc

	// One register access; each channel released at its own handshake
	task automatic axi(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic [1:0] r);
		logic aw_t, w_t, ar_t, e_t;
		int n;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_araddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= wr;
		s_axi_wvalid <= wr;
		s_axi_bready <= wr;
		s_axi_arvalid <= !wr;
		s_axi_rready <= !wr;
		e_t = 1'h0;
		for (n = 0; n < 50 && !e_t; n++) begin
			@(negedge aclk);
			aw_t = s_axi_awvalid && s_axi_awready;
			w_t = s_axi_wvalid && s_axi_wready;
			ar_t = s_axi_arvalid && s_axi_arready;
			e_t = wr ? (s_axi_bready && s_axi_bvalid) : (s_axi_rready && s_axi_rvalid);
			q = s_axi_rdata;
			r = wr ? s_axi_bresp : s_axi_rresp;
			@(posedge aclk);
			if (aw_t) s_axi_awvalid <= 1'h0;
			if (w_t) s_axi_wvalid <= 1'h0;
			if (ar_t) s_axi_arvalid <= 1'h0;
			if (e_t) s_axi_bready <= 1'h0;
			if (e_t) s_axi_rready <= 1'h0;
		end
		if (!e_t) begin
			failures++;
			$display("MISMATCH axi_answer expected 1 seen 0");
			summarize();
		end
	endtask : axi

	// Reset values, read-back and unmapped addresses
	task automatic regs();
		logic [31:0] q;
		logic [1:0] r;
		@(negedge aclk);
		chk("idle_ready", 32'hE, {28'h0, s_axi_awready, s_axi_wready, s_axi_arready, pl_ready});
		axi(1'h0, tsohu_pkg::ADDR_MSS, 32'h0, q, r);
		chk("mss_reset", 32'h0, q);
		axi(1'h1, tsohu_pkg::ADDR_MSS, 32'h0000_05B4, q, r);
		chk("wr_resp", {30'h0, tsohu_pkg::RESP_OKAY}, {30'h0, r});
		axi(1'h0, tsohu_pkg::ADDR_MSS, 32'h0, q, r);
		chk("mss_back", 32'h0000_05B4, q);
		axi(1'h0, 8'h40, 32'h0, q, r);
		chk("unmapped_rd", {30'h0, tsohu_pkg::RESP_SLVERR}, {30'h0, r});
		chk("unmapped_data", 32'h0, q);
		axi(1'h1, 8'h44, 32'h1, q, r);
		chk("unmapped_wr", {30'h0, tsohu_pkg::RESP_SLVERR}, {30'h0, r});
	endtask : regs

	// One large send, every segment judged against worked-out fields
	task automatic send(input logic [31:0] ctl, input logic [15:0] max_segment_size, input logic [19:0] len,
		input logic [15:0] hdr, input logic [15:0] id0, input logic [15:0] psum,
		input logic [15:0] isum, input logic [7:0] flg);
		logic [31:0] q;
		logic [1:0] r;
		logic [19:0] rem;
		logic [15:0] pay, l4, ipl, id, s, e, c;
		logic [7:0] fx;
		logic udp, v6, last, en;
		int n;
		udp = ctl[tsohu_pkg::CTRL_UDP];
		v6 = ctl[tsohu_pkg::CTRL_IPV6];
		axi(1'h1, tsohu_pkg::ADDR_MSS, {16'h0, max_segment_size}, q, r);
		axi(1'h1, tsohu_pkg::ADDR_PAYLEN, {12'h0, len}, q, r);
		axi(1'h1, tsohu_pkg::ADDR_HDRLEN, {16'h0, hdr}, q, r);
		axi(1'h1, tsohu_pkg::ADDR_IPID, {16'h0, id0}, q, r);
		axi(1'h1, tsohu_pkg::ADDR_PSEUDO, {16'h0, psum}, q, r);
		axi(1'h1, tsohu_pkg::ADDR_L4SUM, 32'h0, q, r);
		axi(1'h1, tsohu_pkg::ADDR_IPSUM, {16'h0, isum}, q, r);
		axi(1'h1, tsohu_pkg::ADDR_FLAGS, {24'h0, flg}, q, r);
		axi(1'h1, tsohu_pkg::ADDR_CTRL, ctl, q, r);
		rem = len;
		id = id0;
		while (rem != 20'h0) begin
			pay = (rem < {4'h0, max_segment_size}) ? rem[15:0] : max_segment_size;
			last = (rem == {4'h0, pay});
			l4 = pay + (udp ? tsohu_pkg::UDP_HDR_BYTES : {10'h0, hdr[3:0], 2'h0});
			ipl = {8'h0, hdr[15:8]} + l4;
			fx = flg & ~(tsohu_pkg::TCP_PSH_MASK | tsohu_pkg::TCP_FIN_MASK);
			if (last && ctl[tsohu_pkg::CTRL_PSH])
				fx = fx | tsohu_pkg::TCP_PSH_MASK;
			if (last && ctl[tsohu_pkg::CTRL_FIN])
				fx = fx | tsohu_pkg::TCP_FIN_MASK;
			fx = udp ? 8'h00 : fx;
			// UDP counts its length again in the header, TCP its offset and flags word
			s = oc(oc(psum, l4), udp ? l4 : {hdr[3:0], 4'h0, fx});
			for (n = 0; n < pay / 4; n++)
				s = oc(oc(s, 16'h1122), 16'h3344);
			e = (v6 && udp && s == 16'hFFFF) ? 16'hFFFF : ~s;
			c = ~oc(oc(isum, ipl), id);
			en = !udp || ctl[tsohu_pkg::CTRL_CSUM];
			n = 0;
			do begin
				@(negedge aclk);
				n++;
			end while (seg_valid !== 1'h1 && n < 400);
			chk("seg_valid", 32'h1, {31'h0, seg_valid});
			chk("payload_len", {16'h0, pay}, {16'h0, seg_payload_len});
			chk("l4_len", {16'h0, l4}, {16'h0, seg_l4_len});
			chk("ip_len", {16'h0, ipl}, {16'h0, seg_ip_len});
			chk("ip_id", {16'h0, id}, {16'h0, seg_ip_id});
			chk("last", {31'h0, last}, {31'h0, seg_last});
			chk("ip_csum_en", {31'h0, !v6}, {31'h0, seg_ip_csum_en});
			if (!v6)
				chk("ip_csum", {16'h0, c}, {16'h0, seg_ip_csum});
			chk("tcp_flags", {24'h0, fx}, {24'h0, seg_tcp_flags});
			chk("l4_csum_en", {31'h0, en}, {31'h0, seg_l4_csum_en});
			if (en)
				chk("l4_csum", {16'h0, e}, {16'h0, seg_l4_csum});
			if (seg_valid !== 1'h1)
				summarize();
			@(posedge aclk);
			seg_ready <= 1'h1;
			@(posedge aclk);
			seg_ready <= 1'h0;
			rem = rem - {4'h0, pay};
			id = id + 16'h1;
		end
		axi(1'h0, tsohu_pkg::ADDR_STATUS, 32'h0, q, r);
		chk("status", 32'h0, q);
	endtask : send

	// Reset, registers, then TCP over IPv4, UDP over IPv6, slow UDP over IPv4
	initial begin
		repeat (12) @(posedge aclk);
		aresetn <= 1'h1;
		regs();
		send(32'h39, 16'h8, 20'h14, 16'h1405, 16'hFFFE, 16'h1234, 16'h4500, 8'h18);
		send(32'h0F, 16'h10, 20'h8, 16'h0800, 16'h0001, 16'h7713, 16'h0, 8'h18);
		@(posedge aclk);
		slow <= 1'h1;
		send(32'h05, 16'hC, 20'h18, 16'h1400, 16'h0100, 16'h2222, 16'h4500, 8'h18);
		summarize();
	end
endmodule : tb_top
